/* csrp_top.sv */
// Power state, transmit burst/time-out and boot ROM port registers on Avalon-MM
//
// Notes on behaviour
// (RQ1) Power state is a two-bit field, 00 D0 to 11 D3hot, read back and written as request, reset D0.
// (RQ2) A write of an unsupported power code completes on the bus but leaves the state unchanged.
// (RQ3) A five-bit burst count, reset zero, sets the transmit-done event after that many good bursts.
// (RQ4) A twelve-bit transmit time-out, reset zero, holds deferral plus back-off time.
// (RQ5) The time-out timer counts down only while the deferred interrupt enable bit 28 is set.
// (RQ6) The timer steps every 2.56 us at 100 Mb/s and every 25.6 us at 10 Mb/s.
// (RQ7) Timer expiry before the next transmit start raises the transmit-deferred event.
// (RQ8) The ROM address-16 pin select acts only while the four-LED mode bit 23 is set.
// (RQ9) In four-LED mode, select set (reset one) drives ROM address 16, clear drives the LED.
// (RQ10) The read request bit 27 clears once the read byte stands in data bits 7 to 0.
// (RQ11) The write request bit 26 clears once the byte write to the flash has completed.
// (RQ12) The ROM port holds a 17-bit address in bits 24 to 8 and data in bits 7 to 0, reset zero.
// (RQ13) Setting a request bit runs one byte access at the programmed address and data.
// (RQ14) Software polls the request bit clear before using data or starting another access.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ns
`include "csrp_map.svh"

module csrp_top
  import csrp_pkg::*;
#(
  parameter logic [3:0] PWR_SUPPORTED = 4'h9,
  parameter int         ROM_CYC       = `CSRP_ROM_STROBE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        txStart,
  input  wire logic        txBurstOk,
  input  wire logic        txBurstFail,
  input  wire logic        linkIs100,
  input  wire logic        fdColLedIn,
  output logic             irq,
  output logic      [1:0]  powerState,
  output logic      [15:0] romAddr,
  output logic             romAddr16OrLed,
  output logic             romCs_n,
  output logic             romOe_n,
  output logic             romWe_n,
  output logic      [7:0]  romDataOut,
  output logic             romDataOe_n,
  input  wire logic [7:0]  romDataIn
);

  localparam logic [11:0] TICK100_LAST = 12'(`CSRP_TICK100_CYC - 1);
  localparam logic [11:0] TICK10_LAST  = 12'(`CSRP_TICK10_CYC - 1);
  localparam logic [7:0]  ROM_LAST     = 8'(ROM_CYC - 1);

  logic            waitQ;
  logic [31:0]     rdataQ;
  logic [1:0]      pwrQ;
  logic [4:0]      bcntQ;
  logic [11:0]     ttoQ;
  logic            pinSelQ;
  logic            rdReqQ;
  logic            wrReqQ;
  logic [16:0]     romAddrQ;
  logic [7:0]      romDataQ;
  logic            tdieQ;
  logic            led4Q;
  logic [2:0]      istQ;
  logic [2:0]      ienQ;
  logic            irqQ;
  logic [11:0]     presQ;
  logic [11:0]     tmrQ;
  logic            runQ;
  logic [4:0]      burstQ;
  csrp_rom_state_t romSt;
  logic [7:0]      romCycQ;
  logic            romIsRdQ;
  logic [7:0]      dinS1;
  logic [7:0]      dinS2;
  logic            csQ;
  logic            oeQ;
  logic            weQ;
  logic            doeQ;
  logic            shPinQ;

  // Bus decode: one cycle of waitrequest, write lands when it drops
  wire        wrTake = avs_write & ~waitQ;
  wire        rdLoad = avs_read & waitQ;
  wire        selTxbr = avs_address == `CSRP_TRANSMIT_BURST_AND_TIMEOUT_OFS;
  wire        selRom = avs_address == `CSRP_ROM_OFS;
  wire        selPwr = avs_address == `CSRP_PWR_OFS;
  wire        selAux = avs_address == `CSRP_AUX_OFS;
  wire        selGcr = avs_address == `CSRP_GCR_OFS;
  wire        selIst = avs_address == `CSRP_IST_OFS;
  wire        selIclr = avs_address == `CSRP_ICLR_OFS;
  wire        selIen = avs_address == `CSRP_IEN_OFS;

  wire [31:0] wMask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wMask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wMask) | (avs_writedata & wMask);
  endfunction

  wire [31:0] txbrRd = {11'h0, bcntQ, 4'h0, ttoQ};
  wire [31:0] romRd = {pinSelQ, 3'h0, rdReqQ, wrReqQ, 1'b0, romAddrQ, romDataQ};
  wire [31:0] pwrRd = {30'h0, pwrQ};
  wire [31:0] auxRd = 32'(tdieQ) << `CSRP_TX_DEFERRED_IRQ_ENABLE_BIT;
  wire [31:0] gcrRd = 32'(led4Q) << `CSRP_LED4_BIT;
  wire [31:0] istRd = {29'h0, istQ};
  wire [31:0] ienRd = {29'h0, ienQ};

  // Unmapped addresses and the clear register read as zero
  wire [31:0] rdMux = selTxbr ? txbrRd :
                      selRom  ? romRd  :
                      selPwr  ? pwrRd  :
                      selAux  ? auxRd  :
                      selGcr  ? gcrRd  :
                      selIst  ? istRd  :
                      selIen  ? ienRd  : 32'h0;

  wire [31:0] txbrW = merge(txbrRd);
  wire [31:0] romW = merge(romRd);
  wire [31:0] pwrW = merge(pwrRd);
  wire [31:0] auxW = merge(auxRd);
  wire [31:0] gcrW = merge(gcrRd);
  wire [31:0] ienW = merge(ienRd);
  wire [31:0] clrW = avs_writedata & wMask;

  wire        wTxbr = wrTake & selTxbr;
  wire        wRom = wrTake & selRom;
  wire        romBusy = rdReqQ | wrReqQ;
  // Address, data and request bits are frozen while an access is pending
  wire        wRomFields = wRom & ~romBusy;
  wire [1:0]  pwrNew = pwrW[`CSRP_PWR_MSB:0];
  // (RQ2) Drop unsupported code
  wire        pwrOk = PWR_SUPPORTED[pwrNew];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      waitQ  <= 1'b1;
      rdataQ <= 32'h0;
    end else begin
      waitQ <= ~((avs_read | avs_write) & waitQ);
      if (rdLoad) begin
        rdataQ <= rdMux;
      end
    end
  end

  // (RQ1) Power state field
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pwrQ <= `CSRP_PWR_RST;
    end else if (wrTake & selPwr & pwrOk) begin
      pwrQ <= pwrNew;
    end
  end

  // (RQ3) (RQ4) Burst count and time-out fields
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bcntQ <= 5'h0;
      ttoQ  <= 12'h0;
    end else if (wTxbr) begin
      bcntQ <= txbrW[`CSRP_BCNT_MSB:`CSRP_BCNT_LSB];
      ttoQ  <= txbrW[`CSRP_TTO_MSB:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tdieQ <= 1'b0;
      led4Q <= 1'b0;
      ienQ  <= 3'h0;
    end else if (wrTake) begin
      if (selAux) begin
        tdieQ <= auxW[`CSRP_TX_DEFERRED_IRQ_ENABLE_BIT];
      end
      if (selGcr) begin
        led4Q <= gcrW[`CSRP_LED4_BIT];
      end
      if (selIen) begin
        ienQ <= ienW[2:0];
      end
    end
  end

  // (RQ6) Step rate follows link speed
  wire [11:0] tickLast = linkIs100 ? TICK100_LAST : TICK10_LAST;
  // (RQ5) Prescaler only runs while enabled
  wire        tick = tdieQ & (presQ == 12'h0);
  wire        tmrLoad = txStart | wTxbr;
  wire [11:0] tmrLoadVal = wTxbr ? txbrW[`CSRP_TTO_MSB:0] : ttoQ;
  // (RQ7) Expiry when last unit runs out
  wire        evDef = tick & runQ & ~tmrLoad & (tmrQ == 12'h1);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      presQ <= 12'h0;
    end else if (!tdieQ || presQ == 12'h0) begin
      presQ <= tickLast;
    end else begin
      presQ <= presQ - 12'h1;
    end
  end

  // A new transmit start reloads the timer, so expiry only follows a stall
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tmrQ <= 12'h0;
      runQ <= 1'b0;
    end else if (tmrLoad) begin
      tmrQ <= tmrLoadVal;
      runQ <= tmrLoadVal != 12'h0;
    end else if (tick && runQ) begin
      tmrQ <= tmrQ - 12'h1;
      runQ <= tmrQ != 12'h1;
    end
  end

  // (RQ3) Count consecutive good bursts; a count of zero acts as one
  wire [4:0] burstNext = burstQ + 5'h1;
  wire       evDone = txBurstOk & ~txBurstFail & (burstNext >= bcntQ);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      burstQ <= 5'h0;
    end else if (txBurstFail || evDone) begin
      burstQ <= 5'h0;
    end else if (txBurstOk) begin
      burstQ <= burstNext;
    end
  end

  // ROM access engine
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dinS1 <= 8'h0;
      dinS2 <= 8'h0;
    end else begin
      dinS1 <= romDataIn;
      dinS2 <= dinS1;
    end
  end

  wire romEnd = (romSt == ROM_STROBE) && (romCycQ == ROM_LAST);
  wire evRom = romSt == ROM_DONE;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      romSt    <= ROM_IDLE;
      romCycQ  <= 8'h0;
      romIsRdQ <= 1'b0;
      csQ      <= 1'b1;
      oeQ      <= 1'b1;
      weQ      <= 1'b1;
      doeQ     <= 1'b1;
    end else begin
      case (romSt)
        // (RQ13) Start one access
        ROM_IDLE: begin
          if (romBusy) begin
            romSt    <= ROM_SETUP;
            romIsRdQ <= rdReqQ;
            csQ      <= 1'b0;
            doeQ     <= rdReqQ;
          end
        end
        ROM_SETUP: begin
          romSt   <= ROM_STROBE;
          romCycQ <= 8'h0;
          oeQ     <= ~romIsRdQ;
          weQ     <= romIsRdQ;
        end
        ROM_STROBE: begin
          romCycQ <= romCycQ + 8'h1;
          if (romEnd) begin
            romSt <= ROM_DONE;
            oeQ   <= 1'b1;
            weQ   <= 1'b1;
          end
        end
        ROM_DONE: begin
          romSt <= ROM_IDLE;
          csQ   <= 1'b1;
          doeQ  <= 1'b1;
        end
        default: begin
          romSt <= ROM_IDLE;
        end
      endcase
    end
  end

  // (RQ12) Port address and data fields
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      romAddrQ <= 17'h0;
      romDataQ <= 8'h0;
    end else if (wRomFields) begin
      romAddrQ <= romW[`CSRP_RADDR_MSB:`CSRP_RADDR_LSB];
      romDataQ <= romW[`CSRP_RDATA_MSB:0];
    end else if (romEnd && romIsRdQ) begin
      // Strobe is long enough for the synchroniser to carry the byte
      romDataQ <= dinS2;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pinSelQ <= `CSRP_PINSEL_RST;
      rdReqQ  <= 1'b0;
      wrReqQ  <= 1'b0;
    end else begin
      if (wRom) begin
        pinSelQ <= romW[`CSRP_PINSEL_BIT];
      end
      if (wRomFields) begin
        rdReqQ <= romW[`CSRP_RDREQ_BIT];
        wrReqQ <= romW[`CSRP_WRREQ_BIT] & ~romW[`CSRP_RDREQ_BIT];
      end else if (evRom) begin
        // (RQ10) (RQ11) Request clears on completion
        rdReqQ <= 1'b0;
        wrReqQ <= 1'b0;
      end
    end
  end

  // (RQ8) (RQ9) Shared pin function
  wire shPinD = (led4Q & pinSelQ) ? romAddrQ[16] : fdColLedIn;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shPinQ <= 1'b0;
    end else begin
      shPinQ <= shPinD;
    end
  end

  // Interrupt status: a new event wins over a clear in the same cycle
  wire [2:0] evVec = {evRom, evDef, evDone};
  wire [2:0] clrVec = (wrTake & selIclr) ? clrW[2:0] : 3'h0;
  wire [2:0] istD = (istQ & ~clrVec) | evVec;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      istQ <= 3'h0;
      irqQ <= 1'b0;
    end else begin
      istQ <= istD;
      irqQ <= |(istD & ienQ);
    end
  end

  assign avs_readdata    = rdataQ;
  assign avs_waitrequest = waitQ;
  assign irq             = irqQ;
  assign powerState      = pwrQ;
  assign romAddr         = romAddrQ[15:0];
  assign romAddr16OrLed  = shPinQ;
  assign romCs_n         = csQ;
  assign romOe_n         = oeQ;
  assign romWe_n         = weQ;
  assign romDataOut      = romDataQ;
  assign romDataOe_n     = doeQ;

endmodule

/* csrp_map.svh */
// Register offsets, field positions, reset values and timing counts for the CSR block
`ifndef CSRP_MAP_SVH
`define CSRP_MAP_SVH
`define CSRP_TRANSMIT_BURST_AND_TIMEOUT_OFS 8'h9c
`define CSRP_ROM_OFS 8'ha0
`define CSRP_PWR_OFS 8'hc0
`define CSRP_AUX_OFS 8'hc4
`define CSRP_GCR_OFS 8'hc8
`define CSRP_IST_OFS 8'hcc
`define CSRP_ICLR_OFS 8'hd0
`define CSRP_IEN_OFS 8'hd4
`define CSRP_BCNT_MSB 20
`define CSRP_BCNT_LSB 16
`define CSRP_TTO_MSB 11
`define CSRP_PINSEL_BIT 31
`define CSRP_RDREQ_BIT 27
`define CSRP_WRREQ_BIT 26
`define CSRP_RADDR_MSB 24
`define CSRP_RADDR_LSB 8
`define CSRP_RDATA_MSB 7
`define CSRP_TX_DEFERRED_IRQ_ENABLE_BIT 28
`define CSRP_LED4_BIT 23
`define CSRP_PWR_MSB 1
`define CSRP_IRQ_TXDONE 0
`define CSRP_IRQ_TXDEF 1
`define CSRP_IRQ_ROM 2
`define CSRP_PWR_RST 2'h0
`define CSRP_PINSEL_RST 1'h1
`define CSRP_CLK_NS 10
`define CSRP_TICK100_NS 2560
`define CSRP_TICK10_NS 25600
`define CSRP_TICK100_CYC (`CSRP_TICK100_NS / `CSRP_CLK_NS)
`define CSRP_TICK10_CYC (`CSRP_TICK10_NS / `CSRP_CLK_NS)
`define CSRP_ROM_STROBE_NS 80
`define CSRP_ROM_STROBE_CYC ((`CSRP_ROM_STROBE_NS + `CSRP_CLK_NS - 1) / `CSRP_CLK_NS)
`endif

/* csrp_pkg.sv */
// Types shared by the CSR block
package csrp_pkg;
  typedef enum logic [1:0] {
    ROM_IDLE,
    ROM_SETUP,
    ROM_STROBE,
    ROM_DONE
  } csrp_rom_state_t;
endpackage

/* csrp_top_monitor.sv */
// Concurrent checks on the CSR block ports
`timescale 1ns/1ns
module csrp_top_monitor #(
  parameter logic [3:0] PWR_SUPPORTED = 4'h9,
  parameter int         ROM_CYC       = 8
) (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        irq,
  input wire logic [1:0]  powerState,
  input wire logic [15:0] romAddr,
  input wire logic        romCs_n,
  input wire logic        romOe_n,
  input wire logic        romWe_n,
  input wire logic [7:0]  romDataOut,
  input wire logic        romDataOe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Strobe lengths assume the default strobe count of eight
  a_bus_answer_due: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_wait_one_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_pwr_code_legal: assert property (PWR_SUPPORTED[powerState])
    else $error("unsupported power state held");
  a_pwr_change_cause: assert property (
    !$stable(powerState) |-> $past(avs_write && avs_address == 8'hc0))
    else $error("power state changed without a write");
  a_read_strobe_len: assert property ($fell(romOe_n) |-> !romOe_n [*8] ##1 romOe_n)
    else $error("read strobe length wrong");
  a_write_strobe_len: assert property (
    $fell(romWe_n) |-> (!romWe_n && !romDataOe_n) [*8] ##1 romWe_n)
    else $error("write strobe length or data drive wrong");
  a_strobe_in_frame: assert property (
    !(romOe_n && romWe_n) |-> !romCs_n && (romOe_n || romWe_n))
    else $error("strobe outside chip select or both strobes");
  // A read lands its byte in the data field while chip select is still low
  a_rom_addr_held: assert property (!romCs_n && $past(!romCs_n) |->
    $stable(romAddr) && (romDataOe_n || $stable(romDataOut)))
    else $error("rom address or write data moved during access");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("interrupt dropped without a register write");
  c_rom_read: cover property (!romOe_n ##1 romOe_n);
  c_rom_write: cover property (!romWe_n ##1 romWe_n);
  c_irq_rise: cover property ($rose(irq));
endmodule
bind csrp_top csrp_top_monitor #(.PWR_SUPPORTED(PWR_SUPPORTED), .ROM_CYC(ROM_CYC)) csrp_top_monitor_inst (
  .mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .irq(irq), .powerState(powerState),
  .romAddr(romAddr), .romCs_n(romCs_n), .romOe_n(romOe_n), .romWe_n(romWe_n),
  .romDataOut(romDataOut), .romDataOe_n(romDataOe_n));

/* csrp_flash_model.sv */
// Behavioural byte-wide boot flash on the far side of the ROM port
`timescale 1ns/1ns
module csrp_flash_model (
  input  wire logic        mclk,
  input  wire logic [15:0] romAddr,
  input  wire logic        romAddr16OrLed,
  input  wire logic        romCs_n,
  input  wire logic        romOe_n,
  input  wire logic        romWe_n,
  input  wire logic [7:0]  romDataOut,
  input  wire logic        romDataOe_n,
  output logic      [7:0]  romDataIn
);
  logic [7:0]  mem [logic [16:0]];
  wire  [16:0] fullAddr = {romAddr16OrLed, romAddr};
  initial romDataIn = 8'h00;
  always @(posedge mclk) begin
    if (!romCs_n && !romWe_n && !romDataOe_n)
      mem[fullAddr] = romDataOut;
    // Released bus toggles so a sample one cycle late never matches by chance
    if (!romCs_n && !romOe_n)
      romDataIn <= mem.exists(fullAddr) ? mem[fullAddr] : fullAddr[7:0] ^ 8'h5a;
    else
      romDataIn <= ~romDataIn;
  end
endmodule

/* csr_power_txtimeout_rom_port_test.sv */
// Self-checking bench for the CSR block
`timescale 1ns/1ns
module csr_power_txtimeout_rom_port_test;
  logic        mclk, reset_n, avs_read, avs_write, avs_waitrequest, irq, pin, txStart;
  logic        txBurstOk, txBurstFail, linkIs100, fdColLedIn, romCs_n, romOe_n, romWe_n, dOe_n;
  logic [7:0]  avs_address, romDataOut, romDataIn, fd;
  logic [31:0] avs_writedata, avs_readdata, v;
  logic [15:0] romAddr;
  logic [1:0]  powerState, ps;
  logic [63:0] ent;
  logic [63:0] expQ[$];
  logic [16:0] fa;
  logic [4:0]  bc;
  logic [1:0]  codes [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
  int          error_cnt = 0;
  int          total_checks = 0;
  int          seed = 30;
  int          k;
  csrp_top csrp_top_inst (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .txStart(txStart), .txBurstOk(txBurstOk), .txBurstFail(txBurstFail), .linkIs100(linkIs100),
    .fdColLedIn(fdColLedIn), .irq(irq), .powerState(powerState), .romAddr(romAddr),
    .romAddr16OrLed(pin), .romCs_n(romCs_n), .romOe_n(romOe_n), .romWe_n(romWe_n),
    .romDataOut(romDataOut), .romDataOe_n(dOe_n), .romDataIn(romDataIn));
  csrp_flash_model csrp_flash_model_inst (.mclk(mclk), .romAddr(romAddr), .romAddr16OrLed(pin),
    .romCs_n(romCs_n), .romOe_n(romOe_n), .romWe_n(romWe_n), .romDataOut(romDataOut),
    .romDataOe_n(dOe_n), .romDataIn(romDataIn));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Let one edge pass so a following call never re-drives the strobe in this step
    @(posedge mclk);
    if (n >= 50) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // A zero mask queues a note that is taken but not compared
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back({m, e});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic poll;
    k = 0;
    do begin
      rd(8'ha0, 32'h0, 32'h0);
      k++;
    end while (v[27:26] !== 2'b00 && k < 40);
    chk("request bits", 32'h0, {30'h0, v[27:26]});
  endtask
  task automatic pulse(input logic fail);
    txBurstOk <= !fail;
    txBurstFail <= fail;
    @(posedge mclk);
    txBurstOk <= 1'b0;
    txBurstFail <= 1'b0;
    @(posedge mclk);
  endtask
  function automatic logic [31:0] port(logic [1:0] rq, logic [16:0] a, logic [7:0] d);
    return {1'b1, 3'h0, rq, 1'b0, a, d};
  endfunction
  always @(posedge mclk) begin
    if (avs_read && avs_waitrequest === 1'b0 && expQ.size() > 0) begin
      ent = expQ.pop_front();
      if (ent[63:32] != 32'h0)
        chk("readdata", ent[31:0] & ent[63:32], avs_readdata & ent[63:32]);
    end
  end
  initial begin
    reset_n = 1'b0;
    {avs_read, avs_write, txBurstOk, txBurstFail, fdColLedIn, txStart} = 6'h00;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    linkIs100 = 1'b1;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(8'h9c, 32'h0, '1);
    rd(8'ha0, 32'h80000000, '1);
    wr(8'he0, 32'hffffffff);
    rd(8'he0, 32'h0, '1);
    ps = 2'h0;
    for (int i = 0; i < 4; i++) begin
      wr(8'hc0, {30'h0, codes[i]});
      if (codes[i] == 2'h3 || codes[i] == 2'h0)
        ps = codes[i];
      rd(8'hc0, {30'h0, ps}, '1);
      chk("powerState", {30'h0, ps}, {30'h0, powerState});
    end
    wr(8'hd4, 32'h7);
    bc = 5'd2 + 5'($unsigned($random(seed)) % 4);
    wr(8'h9c, {11'h0, bc, 16'h0});
    repeat (bc - 1) pulse(1'b0);
    pulse(1'b1);
    rd(8'hcc, 32'h0, 32'h1);
    repeat (bc) pulse(1'b0);
    rd(8'hcc, 32'h1, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'hd0, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h9c, 32'h1);
    repeat (600) @(posedge mclk);
    rd(8'hcc, 32'h0, 32'h2);
    wr(8'hc4, 32'h10000000);
    wr(8'h9c, 32'h2);
    repeat (240) @(posedge mclk);
    rd(8'hcc, 32'h0, 32'h2);
    for (k = 0; k < 600 && irq !== 1'b1; k++)
      @(posedge mclk);
    rd(8'hcc, 32'h2, 32'h2);
    chk("expiry cycles", 32'h1, {31'h0, k > 200 && k < 300});
    wr(8'hd4, 32'h5);
    repeat (2) @(posedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'hd0, 32'h2);
    // Starts closer than one step apart keep reloading the timer
    wr(8'h9c, 32'h2);
    for (int i = 0; i < 6; i++) begin
      repeat (200) @(posedge mclk);
      txStart <= 1'b1;
      @(posedge mclk);
      txStart <= 1'b0;
    end
    rd(8'hcc, 32'h0, 32'h2);
    linkIs100 <= 1'b0;
    wr(8'hd4, 32'h7);
    wr(8'h9c, 32'h2);
    repeat (2000) @(posedge mclk);
    rd(8'hcc, 32'h0, 32'h2);
    for (k = 0; k < 3500 && irq !== 1'b1; k++)
      @(posedge mclk);
    rd(8'hcc, 32'h2, 32'h2);
    wr(8'hd0, 32'h2);
    wr(8'hc8, 32'h00800000);
    fa = 17'h10000 | 17'($random(seed) & 16'hffff);
    fd = 8'($random(seed));
    wr(8'ha0, port(2'b01, fa, fd));
    poll();
    rd(8'hcc, 32'h4, 32'h4);
    chk("romAddr16OrLed", 32'h1, {31'h0, pin});
    wr(8'ha0, port(2'b10, fa, 8'h00));
    poll();
    rd(8'ha0, port(2'b00, fa, fd), '1);
    wr(8'ha0, port(2'b10, fa ^ 17'h00100, 8'h00));
    poll();
    rd(8'ha0, port(2'b00, fa ^ 17'h00100, fa[7:0] ^ 8'h5a), '1);
    wr(8'ha0, 32'h0);
    for (int i = 0; i < 2; i++) begin
      fdColLedIn <= i[0];
      repeat (3) @(posedge mclk);
      chk("romAddr16OrLed", {31'h0, i[0]}, {31'h0, pin});
    end
    wr(8'hc8, 32'h0);
    wr(8'ha0, 32'h80000000);
    fdColLedIn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("romAddr16OrLed", 32'h1, {31'h0, pin});
    tally_and_finish();
  end
endmodule
